// ---- hw/wake_countdown_timer.sv ----
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - Each 35-bit counter loads its start value, then decrements each slow period.
// - The tick after reaching zero fires the timer, reloads 0x7FFFFFFF, keeps counting.
// - Start value counts slow periods; 32 means one millisecond nominally.
// - Stop halts counting and raises no interrupt.
// - Stop leaves the interrupt enable unchanged for a later restart.
// - Reading a counter returns its value without disturbing it.
// - Two timers, numbered 0 and 1, addressed individually, may run together.
// - Running bitmap: bit 0 timer 0, bit 1 timer 1, set while running.
// - Running stays set across reloads; only a stop or the end of a calibration clears it.
// - Expired bitmap holds sticky bits per timer; reading clears them.
// - Calibration holds timer 0 for twenty slow periods, counting core cycles.
// - Calibration result reads 10000 at nominal; larger means slower clock.
// - Each timer has its own interrupt enable; enabled expiry sets its status bit, and the mask gates irq.
// - Writing a timer's interrupt enable also stops that timer.
module wake_countdown_timer
  import wake_countdown_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              slow_clk,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq
);

  logic                   rst_meta_q;
  logic                   rst_n_q;
  logic                   slow_meta_q;
  logic                   slow_sync_q;
  logic                   slow_prev_q;
  logic [DATA_W-1:0]      load_q [NUM_TIMERS];
  logic [NUM_TIMERS-1:0]  irq_en_q;
  logic [NUM_TIMERS-1:0]  expired_q;
  logic [NUM_TIMERS-1:0]  expired_d;
  logic [INT_W-1:0]       int_stat_q;
  logic [INT_W-1:0]       int_stat_d;
  logic [INT_W-1:0]       int_mask_q;
  logic [DATA_W-1:0]      rdata_q;
  logic                   irq_q;
  logic [CNT_W-1:0]       count [NUM_TIMERS];
  logic [NUM_TIMERS-1:0]  run;
  logic [NUM_TIMERS-1:0]  fire;
  logic [NUM_TIMERS-1:0]  start_cmd;
  logic [NUM_TIMERS-1:0]  stop_cmd;
  logic                   cal_busy;
  logic                   cal_done;
  logic [DATA_W-1:0]      cal_result;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Slow clock is a pin: two flops, then a third for the edge detect
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= slow_clk;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end

  // One core cycle per slow period, on its rising edge
  wire logic slow_tick = slow_sync_q && !slow_prev_q;

  // Register decode
  wire logic wr_load0   = reg_wr && (reg_addr == LOAD0_OFFSET);
  wire logic wr_load1   = reg_wr && (reg_addr == LOAD1_OFFSET);
  wire logic wr_cmd     = reg_wr && (reg_addr == CMD_OFFSET);
  wire logic wr_irq_en  = reg_wr && (reg_addr == IRQ_EN_OFFSET);
  wire logic wr_int_st  = reg_wr && (reg_addr == INT_STAT_OFFSET);
  wire logic wr_int_msk = reg_wr && (reg_addr == INT_MASK_OFFSET);
  wire logic rd_expired = reg_rd && (reg_addr == EXPIRED_OFFSET);

  // Command fields
  wire logic cmd_sel   = reg_wdata[CMD_SEL_BIT];
  wire logic cmd_start = wr_cmd && reg_wdata[CMD_START_BIT];
  wire logic cmd_stop  = wr_cmd && reg_wdata[CMD_STOP_BIT];
  wire logic cmd_cal   = wr_cmd && reg_wdata[CMD_CAL_BIT] && !cal_busy;
  wire logic ie_sel    = reg_wdata[IE_SEL_BIT];
  wire logic ie_val    = reg_wdata[IE_EN_BIT];

  // A bit per timer: start, stop; timer 0 is held off while calibrating
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_cmd
      wire logic hit = (cmd_sel == 1'(i));
      wire logic own = !(i == 0 && cal_busy);
      assign start_cmd[i] = cmd_start && hit && own && !cmd_stop;
      assign stop_cmd[i]  = (cmd_stop && hit)
                          || (wr_irq_en && ie_sel == 1'(i))
                          || (i == 0 && cmd_cal);
    end
  endgenerate

  // Two independent counters
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
      wake_countdown_channel u_channel (
        .clk         (core_clk),
        .rst_n       (rst_n_q),
        .tick        (slow_tick),
        .start       (start_cmd[i]),
        .stop        (stop_cmd[i]),
        .start_value (CNT_W'(load_q[i])),
        .count_q     (count[i]),
        .run_q       (run[i]),
        .fire_q      (fire[i])
      );
    end
  endgenerate

  // Slow clock measurement borrows timer 0
  wake_countdown_cal u_cal (
    .clk      (core_clk),
    .rst_n    (rst_n_q),
    .tick     (slow_tick),
    .req      (cmd_cal),
    .busy_q   (cal_busy),
    .done_q   (cal_done),
    .result_q (cal_result)
  );

  // Running view; calibration counts as timer 0 running
  wire logic [NUM_TIMERS-1:0] running_map = {run[1], run[0] || cal_busy};

  // Expiry events; timer 0 is stopped while measuring, gate anyway
  wire logic [NUM_TIMERS-1:0] fire_evt = {fire[1], fire[0] && !cal_busy};

  // Sticky expired bits, cleared by reading, set wins the tie
  assign expired_d = (expired_q & ~({NUM_TIMERS{rd_expired}})) | fire_evt;

  // Interrupt events: enabled expiry per timer, and calibration done
  wire logic [INT_W-1:0] int_evt = {cal_done, fire_evt & irq_en_q};
  wire logic [INT_W-1:0] int_clr = wr_int_st ? reg_wdata[INT_W-1:0] : '0;
  assign int_stat_d = (int_stat_q & ~int_clr) | int_evt;

  // Read mux; counters are sampled live so software sees elapsed time
  wire logic [DATA_W-1:0] rd_mux =
      (reg_addr == LOAD0_OFFSET)     ? load_q[0] :
      (reg_addr == LOAD1_OFFSET)     ? load_q[1] :
      (reg_addr == IRQ_EN_OFFSET)    ? DATA_W'(irq_en_q) :
      (reg_addr == COUNT0_LO_OFFSET) ? count[0][DATA_W-1:0] :
      (reg_addr == COUNT0_HI_OFFSET) ? DATA_W'(count[0][CNT_W-1:DATA_W]) :
      (reg_addr == COUNT1_LO_OFFSET) ? count[1][DATA_W-1:0] :
      (reg_addr == COUNT1_HI_OFFSET) ? DATA_W'(count[1][CNT_W-1:DATA_W]) :
      (reg_addr == RUNNING_OFFSET)   ? DATA_W'(running_map) :
      (reg_addr == EXPIRED_OFFSET)   ? DATA_W'(expired_q) :
      (reg_addr == CAL_OFFSET)       ? (cal_result | (DATA_W'(cal_busy) << CAL_BUSY_BIT)) :
      (reg_addr == INT_STAT_OFFSET)  ? DATA_W'(int_stat_q) :
      (reg_addr == INT_MASK_OFFSET)  ? DATA_W'(int_mask_q) :
      '0;

  // Start values held per timer
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_q[0] <= '0;
      load_q[1] <= '0;
    end else begin
      if (wr_load0) load_q[0] <= reg_wdata;
      if (wr_load1) load_q[1] <= reg_wdata;
    end
  end

  // Interrupt enables change only through their own write, never by stop
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_en_q <= '0;
    end else if (wr_irq_en) begin
      irq_en_q[ie_sel] <= ie_val;
    end
  end

  // Status, mask and interrupt line
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      expired_q  <= '0;
      int_stat_q <= '0;
      int_mask_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      expired_q  <= expired_d;
      int_stat_q <= int_stat_d;
      if (wr_int_msk) int_mask_q <= reg_wdata[INT_W-1:0];
      irq_q      <= |(int_stat_d & (wr_int_msk ? reg_wdata[INT_W-1:0] : int_mask_q));
    end
  end

  // Read data live for exactly the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

  // Checks, all in the core clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n_q);

  running_view_a : assert property (
    reg_rd && reg_addr == RUNNING_OFFSET
    |=> reg_rdata == DATA_W'({$past(run[1]), $past(run[0]) || $past(cal_busy)}))
    else $error("running bitmap read wrong");

  active_reload_a : assert property (
    fire[0] && !stop_cmd[0] |-> run[0] ##1 run[0])
    else $error("timer 0 went idle at reload");

  expired_read_a : assert property (
    rd_expired && fire_evt == '0
    |=> expired_q == '0 && reg_rdata == DATA_W'($past(expired_q)))
    else $error("expired bits survived a read");

  expired_set_a : assert property (
    fire[1] |=> expired_q[1])
    else $error("expiry lost");

  enable_stops_a : assert property (
    wr_irq_en && !ie_sel |=> !run[0] ##1 !run[0] || $past(start_cmd[0]))
    else $error("enable write did not stop timer 0");

  enable_kept_a : assert property (
    wr_cmd && reg_wdata[CMD_STOP_BIT] && !wr_irq_en |=> $stable(irq_en_q))
    else $error("stop changed the interrupt enable");

  irq_raise_a : assert property (
    fire[0] && irq_en_q[0] && !cal_busy && int_mask_q[0] && !wr_int_msk
    |=> int_stat_q[0] && irq)
    else $error("enabled expiry did not interrupt");

  count_read_a : assert property (
    reg_rd && reg_addr == COUNT1_LO_OFFSET && run[1]
    |=> reg_rdata == $past(count[1][DATA_W-1:0]) && run[1])
    else $error("count read wrong or disturbed the timer");

  cal_active_a : assert property (
    cal_busy |-> running_map[0] && !run[0] && !fire[0])
    else $error("calibration not shown as timer 0 activity");

  stop_quiet_a : assert property (
    stop_cmd[1] |=> !run[1] ##1 !fire[1] || $past(start_cmd[1]))
    else $error("stopped timer fired");

  rdata_idle_a : assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not cleared between reads");

  irq_level_a : assert property (
    irq == |(int_stat_q & int_mask_q))
    else $error("interrupt line disagrees with masked status");

  expired_tie_a : assert property (
    fire_evt[0] && rd_expired |=> expired_q[0])
    else $error("same-cycle read cleared a new expiry");

  expired_hold_a : assert property (
    expired_q[1] && !rd_expired |=> expired_q[1])
    else $error("expired bit dropped without a read");

  cal_pulse_a : assert property (
    cal_done |=> !cal_done)
    else $error("calibration done held too long");

  start_load_a : assert property (
    start_cmd[1] |=> run[1] && count[1] == CNT_W'($past(load_q[1])))
    else $error("start did not load the start value");

  count_hold_a : assert property (
    !run[0] && !start_cmd[0] |=> $stable(count[0]))
    else $error("idle counter moved");

  idle_quiet_a : assert property (
    !run[1] |=> !fire[1])
    else $error("idle timer fired");

  run_keep_a : assert property (
    run[1] && !stop_cmd[1] |=> run[1])
    else $error("timer went idle without a stop");

  enable_write_a : assert property (
    wr_irq_en && ie_sel |=> irq_en_q[1] == $past(ie_val))
    else $error("interrupt enable write lost");

  enable_other_a : assert property (
    !wr_irq_en |=> $stable(irq_en_q))
    else $error("interrupt enable changed without its write");

  int_clear_a : assert property (
    wr_int_st && reg_wdata[0] && !int_evt[0] |=> !int_stat_q[0])
    else $error("status bit survived its clear");

  cal_irq_a : assert property (
    cal_done |=> int_stat_q[INT_CAL_BIT])
    else $error("calibration done not flagged");

  count_hi_read_a : assert property (
    reg_rd && reg_addr == COUNT0_HI_OFFSET
    |=> reg_rdata == DATA_W'($past(count[0][CNT_W-1:DATA_W])))
    else $error("count upper bits read wrong");

  cal_no_expire_a : assert property (
    cal_busy && !expired_q[0] |=> !expired_q[0])
    else $error("calibration set the expired bit");

  tick_pulse_a : assert property (
    slow_tick |=> !slow_tick)
    else $error("slow tick longer than one cycle");

  load_write_a : assert property (
    wr_load0 |=> load_q[0] == $past(reg_wdata))
    else $error("start value write lost");

  mask_write_a : assert property (
    wr_int_msk |=> int_mask_q == $past(reg_wdata[INT_W-1:0]))
    else $error("mask write lost");

  cal_accept_a : assert property (
    cmd_cal |=> cal_busy)
    else $error("calibration request not taken");

  fire_pulse_a : assert property (
    fire[1] |=> !fire[1])
    else $error("fire held for two cycles");

endmodule : wake_countdown_timer

// ---- hw/wake_countdown_pkg.sv ----
package wake_countdown_pkg;

  // Counter geometry and reload point
  localparam int              CNT_W        = 35;
  localparam int              NUM_TIMERS   = 2;
  localparam logic [34:0]     RELOAD_VALUE = 35'h0_7FFF_FFFF;
  localparam logic [34:0]     COUNT_RESET  = 35'h0_0000_0000;

  // Clock rates and calibration timing
  localparam int unsigned     CORE_HZ            = 10_000_000;
  localparam int unsigned     SLOW_HZ            = 32_000;
  localparam int unsigned     CAL_PERIODS        = 20;
  localparam int unsigned     CAL_SCALE          = 10_000;
  localparam int unsigned     CAL_NOMINAL_CYCLES = CORE_HZ * CAL_PERIODS / SLOW_HZ;
  localparam int              CAL_CYC_W          = 16;
  localparam int              TICK_CNT_W         = 5;
  localparam logic [4:0]      CAL_LAST_TICK      = 5'h13;

  // Register bus geometry
  localparam int              ADDR_W = 8;
  localparam int              DATA_W = 32;

  // Register offsets
  localparam logic [7:0]      LOAD0_OFFSET    = 8'h00;
  localparam logic [7:0]      LOAD1_OFFSET    = 8'h04;
  localparam logic [7:0]      CMD_OFFSET      = 8'h08;
  localparam logic [7:0]      IRQ_EN_OFFSET   = 8'h0C;
  localparam logic [7:0]      COUNT0_LO_OFFSET = 8'h10;
  localparam logic [7:0]      COUNT0_HI_OFFSET = 8'h14;
  localparam logic [7:0]      COUNT1_LO_OFFSET = 8'h18;
  localparam logic [7:0]      COUNT1_HI_OFFSET = 8'h1C;
  localparam logic [7:0]      RUNNING_OFFSET  = 8'h20;
  localparam logic [7:0]      EXPIRED_OFFSET  = 8'h24;
  localparam logic [7:0]      CAL_OFFSET      = 8'h28;
  localparam logic [7:0]      INT_STAT_OFFSET = 8'h2C;
  localparam logic [7:0]      INT_MASK_OFFSET = 8'h30;

  // Field positions
  localparam int              CMD_SEL_BIT   = 0;
  localparam int              CMD_START_BIT = 1;
  localparam int              CMD_STOP_BIT  = 2;
  localparam int              CMD_CAL_BIT   = 3;
  localparam int              IE_SEL_BIT    = 0;
  localparam int              IE_EN_BIT     = 1;
  localparam int              CAL_BUSY_BIT  = 31;
  localparam int              INT_CAL_BIT   = 2;
  localparam int              INT_W         = 3;

  // Calibration sequencer, Gray along idle-align-measure
  typedef enum logic [1:0] {
    CAL_IDLE    = 2'b00,
    CAL_ALIGN   = 2'b01,
    CAL_MEASURE = 2'b11
  } cal_state_type;

endpackage : wake_countdown_pkg

// ---- hw/wake_countdown_channel.sv ----
`timescale 1ns/10ps
module wake_countdown_channel
  import wake_countdown_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [CNT_W-1:0] start_value,
  output logic      [CNT_W-1:0] count_q,
  output logic                  run_q,
  output logic                  fire_q
);

  // Decrement only on a slow tick while running and no command pending
  wire logic at_zero = (count_q == COUNT_RESET);
  wire logic step    = tick && run_q && !start && !stop;

  // Stop beats start; stop keeps the count so it can still be read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RESET;
      run_q   <= 1'b0;
      fire_q  <= 1'b0;
    end else begin
      fire_q <= step && at_zero;
      if (stop) begin
        run_q <= 1'b0;
      end else if (start) begin
        run_q <= 1'b1;
      end
      if (start && !stop) begin
        count_q <= start_value;
      end else if (step) begin
        count_q <= at_zero ? RELOAD_VALUE : CNT_W'(count_q - 1'b1);
      end
    end
  end

  reload_fire_a : assert property (@(posedge clk) disable iff (!rst_n)
    step && at_zero |=> fire_q && run_q && count_q == RELOAD_VALUE)
    else $error("zero crossing did not fire and reload");

  step_down_a : assert property (@(posedge clk) disable iff (!rst_n)
    step && !at_zero |=> count_q == $past(count_q) - 1 && !fire_q)
    else $error("count did not drop by one on a tick");

  stop_halt_a : assert property (@(posedge clk) disable iff (!rst_n)
    stop |=> !run_q && !fire_q && count_q == $past(count_q))
    else $error("stop did not halt quietly");

endmodule : wake_countdown_channel

// ---- hw/wake_countdown_cal.sv ----
`timescale 1ns/10ps
module wake_countdown_cal
  import wake_countdown_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic              req,
  output logic                   busy_q,
  output logic                   done_q,
  output logic [DATA_W-1:0]      result_q
);

  cal_state_type             state_q;
  cal_state_type             state_d;
  logic [TICK_CNT_W-1:0]     ticks_q;
  logic [CAL_CYC_W-1:0]      cyc_q;

  // Window ends on the twentieth slow edge after the aligning edge
  wire logic last_tick = tick && (ticks_q == CAL_LAST_TICK);
  wire logic [DATA_W-1:0] scaled =
    DATA_W'((DATA_W'(cyc_q) + 1) * CAL_SCALE / CAL_NOMINAL_CYCLES);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      CAL_IDLE:    if (req) state_d = CAL_ALIGN;
      CAL_ALIGN:   if (tick) state_d = CAL_MEASURE;
      CAL_MEASURE: if (last_tick) state_d = CAL_IDLE;
      default:     state_d = CAL_IDLE;
    endcase
  end

  // Count core cycles over the window; saturate rather than wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= CAL_IDLE;
      ticks_q  <= '0;
      cyc_q    <= '0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      result_q <= '0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d != CAL_IDLE);
      done_q  <= (state_q == CAL_MEASURE) && last_tick;
      if (state_q != CAL_MEASURE) begin
        ticks_q <= '0;
        cyc_q   <= '0;
      end else begin
        if (tick) ticks_q <= TICK_CNT_W'(ticks_q + 1'b1);
        if (cyc_q != '1) cyc_q <= CAL_CYC_W'(cyc_q + 1'b1);
      end
      if ((state_q == CAL_MEASURE) && last_tick) result_q <= scaled;
    end
  end

  cal_window_a : assert property (@(posedge clk) disable iff (!rst_n)
    state_q == CAL_MEASURE && last_tick |=> done_q && !busy_q)
    else $error("calibration window did not close on the last tick");

endmodule : wake_countdown_cal

// ---- tb/wake_countdown_timer_tb_top.sv ----
`timescale 1ns/10ps
module wake_countdown_timer_tb_top
  import wake_countdown_pkg::*;
;
  typedef struct {
    logic [DATA_W-1:0] exp;
    logic [DATA_W-1:0] msk;
  } note_type;

  localparam logic [DATA_W-1:0] ALL_BITS = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] BIT0     = 32'h0000_0001;
  localparam logic [DATA_W-1:0] BIT1     = 32'h0000_0002;
  localparam logic [DATA_W-1:0] BIT2     = 32'h0000_0004;
  localparam logic [DATA_W-1:0] BITS01   = 32'h0000_0003;
  localparam logic [DATA_W-1:0] NONE     = 32'h0000_0000;

  logic              core_clk;
  logic              nrst;
  logic              slow_clk;
  logic              cal_pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  logic              rd_d;
  logic [DATA_W-1:0] last_rdata;
  logic [DATA_W-1:0] cal_want;
  note_type          notes[$];
  int                errors;
  int                samples_checked;
  int                cal_half;
  int                n_start;
  int                i;

  wake_countdown_timer u_wake_countdown_timer (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .slow_clk  (slow_clk ^ cal_pin),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq)
  );

  // Core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Free-running slow clock, from the first calibration until after the last one; phase unrelated to core
  initial begin
    forever begin
      wait (cal_half != 0);
      #(cal_half) cal_pin <= ~cal_pin;
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Strobe stays up after its edge; the next call or idle() sets each strobe once
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input logic [DATA_W-1:0] m);
    notes.push_back('{exp: e, msk: m});
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
  endtask : rd

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle

  // One slow tick per pulse; wide enough for the two-flop synchroniser
  task automatic ticks(input int n);
    idle(0);
    repeat (n) begin
      slow_clk <= 1'b1;
      repeat (6) @(posedge core_clk);
      slow_clk <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask : ticks

  task automatic chk_irq(input logic want);
    idle(3);
    check({31'h0000_0000, irq}, {31'h0000_0000, want});
  endtask : chk_irq

  // Read-data watcher: oldest note against the data standing one cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d === 1'b1) begin
      check(reg_rdata & notes[0].msk, notes[0].exp & notes[0].msk);
      void'(notes.pop_front());
      last_rdata <= reg_rdata;
    end
    rd_d <= reg_rd;
  end

  initial begin
    nrst      = 1'b0;
    slow_clk  = 1'b0;
    cal_pin   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rd_d      = 1'b0;
    cal_half  = 0;
    errors    = 0;
    samples_checked = 0;
    void'($urandom(80));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Idle after reset, one unmapped hole
    rd(RUNNING_OFFSET, NONE, ALL_BITS);
    rd(EXPIRED_OFFSET, NONE, ALL_BITS);
    rd(COUNT0_LO_OFFSET, NONE, ALL_BITS);
    rd(8'h40, NONE, ALL_BITS);
    chk_irq(1'b0);
    // Timer 0 with its interrupt armed before the start
    n_start = 2 + ($urandom % 8);
    wr(INT_MASK_OFFSET, 32'h0000_0007);
    wr(IRQ_EN_OFFSET, 32'h0000_0002);
    wr(LOAD0_OFFSET, 32'(n_start));
    wr(CMD_OFFSET, 32'h0000_0002);
    rd(COUNT0_LO_OFFSET, 32'(n_start), ALL_BITS);
    rd(RUNNING_OFFSET, BIT0, BITS01);
    ticks(n_start);
    rd(COUNT0_LO_OFFSET, NONE, ALL_BITS);
    rd(COUNT0_LO_OFFSET, NONE, ALL_BITS);
    chk_irq(1'b0);
    ticks(1);
    rd(COUNT0_LO_OFFSET, 32'h7FFF_FFFF, ALL_BITS);
    rd(COUNT0_HI_OFFSET, NONE, ALL_BITS);
    rd(RUNNING_OFFSET, BIT0, BIT0);
    rd(INT_STAT_OFFSET, BIT0, 32'h0000_0007);
    chk_irq(1'b1);
    wr(INT_MASK_OFFSET, NONE);
    chk_irq(1'b0);
    wr(INT_MASK_OFFSET, 32'h0000_0007);
    chk_irq(1'b1);
    wr(INT_STAT_OFFSET, BIT0);
    chk_irq(1'b0);
    rd(EXPIRED_OFFSET, BIT0, BITS01);
    rd(EXPIRED_OFFSET, NONE, BITS01);
    ticks(1);
    rd(COUNT0_LO_OFFSET, 32'h7FFF_FFFE, ALL_BITS);
    // Timer 1 alongside, interrupt left off
    n_start = 2 + ($urandom % 8);
    wr(LOAD1_OFFSET, 32'(n_start));
    wr(CMD_OFFSET, 32'h0000_0003);
    rd(RUNNING_OFFSET, BITS01, BITS01);
    ticks(n_start + 1);
    rd(COUNT1_LO_OFFSET, 32'h7FFF_FFFF, ALL_BITS);
    rd(COUNT0_LO_OFFSET, 32'h7FFF_FFFD - 32'(n_start), ALL_BITS);
    rd(EXPIRED_OFFSET, BIT1, BITS01);
    rd(INT_STAT_OFFSET, NONE, BITS01);
    chk_irq(1'b0);
    // Enable write stops timer 1; stop command halts timer 0
    wr(IRQ_EN_OFFSET, 32'h0000_0001);
    rd(RUNNING_OFFSET, BIT0, BITS01);
    wr(CMD_OFFSET, 32'h0000_0004);
    rd(RUNNING_OFFSET, NONE, BITS01);
    ticks(2);
    rd(COUNT0_LO_OFFSET, 32'h7FFF_FFFD - 32'(n_start), ALL_BITS);
    rd(INT_STAT_OFFSET, NONE, ALL_BITS);
    rd(IRQ_EN_OFFSET, BIT0, BITS01);
    chk_irq(1'b0);
    // Restart: the kept enable still raises the interrupt
    wr(LOAD0_OFFSET, 32'h0000_0002);
    wr(CMD_OFFSET, 32'h0000_0002);
    ticks(3);
    chk_irq(1'b1);
    wr(INT_STAT_OFFSET, BIT0);
    wr(CMD_OFFSET, 32'h0000_0004);
    rd(EXPIRED_OFFSET, BIT0, BITS01);
    // Calibration at fast, nominal and slow rates
    for (int k = 0; k < 3; k++) begin
      cal_half = 12500 + 3125 * k;
      cal_want = 32'(cal_half * 16 / 25);
      wr(CMD_OFFSET, 32'h0000_0008);
      rd(RUNNING_OFFSET, BIT0, BIT0);
      // Start of timer 0 is refused while measuring
      wr(CMD_OFFSET, 32'h0000_0002);
      for (i = 0; i < 6000; i++) begin
        rd(CAL_OFFSET, NONE, NONE);
        idle(2);
        if (last_rdata[CAL_BUSY_BIT] == 1'b0) break;
      end
      if (i == 6000) begin
        errors++;
        tally_and_finish();
      end
      // Sync jitter allows a few counts either way
      check({31'h0000_0000, (last_rdata[30:0] + 31'h0000_000A >= cal_want[30:0]) &&
             (last_rdata[30:0] <= cal_want[30:0] + 31'h0000_000A)}, BIT0);
      rd(RUNNING_OFFSET, NONE, BIT0);
      rd(EXPIRED_OFFSET, NONE, BIT0);
      rd(INT_STAT_OFFSET, BIT2, BIT2);
      chk_irq(1'b1);
      wr(INT_STAT_OFFSET, BIT2);
      chk_irq(1'b0);
    end
    // Park the slow clock once its last toggle has passed
    cal_half = 0;
    repeat (200) @(posedge core_clk);
    cal_pin  <= 1'b0;
    repeat (4) @(posedge core_clk);
    tally_and_finish();
  end

endmodule : wake_countdown_timer_tb_top
